// ### rtl/tec_pkg.sv
package tec_pkg;
  // register offsets on the plain register port
  localparam logic [7:0] TEC_OFS_MODE = 8'h00;
  localparam logic [7:0] TEC_OFS_PRESCALE = 8'h04;
  localparam logic [7:0] TEC_OFS_OUTCTRL = 8'h08;
  localparam logic [7:0] TEC_OFS_CMP_A = 8'h0C;
  localparam logic [7:0] TEC_OFS_CMP_B = 8'h10;
  localparam logic [7:0] TEC_OFS_COUNT = 8'h14;
  localparam logic [7:0] TEC_OFS_IRQ_STAT = 8'h18;
  localparam logic [7:0] TEC_OFS_IRQ_MASK = 8'h1C;
  // field positions
  localparam int TEC_MODE_POS = 2;
  localparam int TEC_CLKSEL_POS = 0;
  localparam int TEC_EDGESEL_POS = 4;
  localparam int TEC_OUTEN_POS = 0;
  localparam int TEC_INV_POS = 1;
  localparam int TEC_IRQ_A_POS = 0;
  localparam int TEC_IRQ_B_POS = 1;
  // reset values
  localparam logic [1:0] TEC_MODE_RST = 2'h0;
  localparam logic [7:0] TEC_PRESCALE_RST = 8'h00;
  localparam logic [1:0] TEC_OUTCTRL_RST = 2'h0;
  localparam logic [15:0] TEC_CMP_RST = 16'h0000;
  localparam logic [1:0] TEC_IRQ_RST = 2'h0;
  localparam logic [1:0] TEC_IRQ_MASK_RST = 2'h3;
  // prescaler: divide by 256
  localparam logic [7:0] TEC_PRE_LAST = 8'hFF;
  localparam logic [15:0] TEC_CNT_MAX = 16'hFFFF;

  typedef enum logic [1:0] {
    TEC_OP_STOP = 2'h0,
    TEC_OP_FREE = 2'h1,
    TEC_OP_EDGE_CLR = 2'h2,
    TEC_OP_MATCH_CLR = 2'h3
  } tec_op_t;

  typedef enum logic [1:0] {
    TEC_CLK_PERIPH = 2'h0,
    TEC_CLK_DIV256 = 2'h1,
    TEC_CLK_CASCADE = 2'h2,
    TEC_CLK_EVENT = 2'h3
  } tec_clksel_t;

  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } tec_bus_req_t;
endpackage

// ### rtl/tec_edge_det.sv
`timescale 1ns/100ps
module tec_edge_det (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic pin_in,
  input wire logic [1:0] edge_sel,
  output logic edge_pulse
);
  import tec_pkg::*;

  logic sync1_q, sync2_q, samp_q, lvl_q;

  // two-flop synchroniser, then one more sample
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      samp_q <= 1'b0;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
      samp_q <= sync2_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lvl_q <= 1'b0;
    end else if (sync2_q == samp_q) begin
      lvl_q <= samp_q;
    end
  end

  always_comb begin
    unique case (edge_sel)
      2'h0: edge_pulse = lvl_q & ~samp_q & (sync2_q == samp_q);
      2'h1: edge_pulse = ~lvl_q & samp_q & (sync2_q == samp_q);
      2'h3: edge_pulse = (lvl_q != samp_q) & (sync2_q == samp_q);
      default: edge_pulse = 1'b0;
    endcase
  end

  a_filter_two_samples: assert property (
    @(posedge sys_clk) disable iff (rst)
    edge_pulse |-> (sync2_q == samp_q) && (lvl_q != samp_q))
    else $error("edge accepted without two equal samples");
endmodule

// ### rtl/tec_timer.sv
// Operation
// - output control 03H while interval timing gives a square wave on the pin.
// - mode 11 clears on compare A match, counting synchronous with count clock.
// - compare A match in mode 11 clears counter, raises irq A, inverts output.
// - each output half period after the first lasts compare value plus one count clocks; the first lasts M+2.
// - compare B match always raises irq B; software masks it if unused.
// - clock select 11 with mode 11 counts event edges, irq A on match.
// - first event-count irq after M+2 edges, later ones every M+1.
// - event pin edge accepted only after two consecutive equal samples.
// - mode 10 counts; valid edge clears to zero; overflow keeps counting.
// - mode 10 starts counting at once, without waiting for an edge.
// - mode 10 raises irq A and irq B on their compare matches.
// - output enable low forces pin low; invert bit gates toggle, irq stays.
// - clock select picks peripheral clock, divide by 256, cascade, event edge.
// - edge select 00 falling, 01 rising, 11 both; 10 unused.
`timescale 1ns/100ps
module tec_timer (
  input wire logic sys_clk,
  input wire logic rst,
  input tec_pkg::tec_bus_req_t bus_req,
  output logic [15:0] rd_data,
  input wire logic event_in_pin,
  input wire logic cascade_timer_irq,
  output logic timer_out_pin,
  output logic irq
);
  import tec_pkg::*;

  tec_op_t op_mode_q;
  logic [7:0] prescale_mode_q;
  logic [1:0] out_ctrl_q;
  logic [15:0] cmp_a_q, cmp_b_q, cnt_q;
  logic [1:0] irq_stat_q, irq_mask_q;
  logic [7:0] pre_q;
  logic started_q, lvl_q, out_pin_q, irq_q;
  logic [15:0] rd_data_q;
  logic run, tick, ev_edge, edge_clr, hit_a, hit_b, clr_on_a;
  logic out_en, inv_en;
  tec_clksel_t clk_sel;
  logic [1:0] irq_set, irq_clr;

  assign clk_sel = tec_clksel_t'(prescale_mode_q[TEC_CLKSEL_POS +: 2]);
  assign out_en = out_ctrl_q[TEC_OUTEN_POS];
  assign inv_en = out_ctrl_q[TEC_INV_POS];
  assign run = (op_mode_q != TEC_OP_STOP);

  // event pin synchroniser, filter and edge select
  tec_edge_det u_edge (
    .sys_clk(sys_clk),
    .rst(rst),
    .pin_in(event_in_pin),
    .edge_sel(prescale_mode_q[TEC_EDGESEL_POS +: 2]),
    .edge_pulse(ev_edge)
  );

  // register writes
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      op_mode_q <= TEC_OP_STOP;
      prescale_mode_q <= TEC_PRESCALE_RST;
      out_ctrl_q <= TEC_OUTCTRL_RST;
      cmp_a_q <= TEC_CMP_RST;
      cmp_b_q <= TEC_CMP_RST;
      irq_mask_q <= TEC_IRQ_MASK_RST;
    end else if (bus_req.wr) begin
      unique case (bus_req.addr)
        TEC_OFS_MODE: op_mode_q <= tec_op_t'(bus_req.wdata[TEC_MODE_POS +: 2]);
        TEC_OFS_PRESCALE: prescale_mode_q <= bus_req.wdata[7:0] & 8'hF3;
        TEC_OFS_OUTCTRL: out_ctrl_q <= bus_req.wdata[1:0];
        TEC_OFS_CMP_A: cmp_a_q <= bus_req.wdata;
        TEC_OFS_CMP_B: cmp_b_q <= bus_req.wdata;
        TEC_OFS_IRQ_MASK: irq_mask_q <= bus_req.wdata[1:0];
        default: ;
      endcase
    end
  end

  // prescaler for the divide-by-256 clock
  always_ff @(posedge sys_clk) begin
    if (rst || !run) begin
      pre_q <= 8'h00;
    end else begin
      pre_q <= pre_q + 8'h01;
    end
  end

  always_comb begin
    unique case (clk_sel)
      TEC_CLK_PERIPH: tick = 1'b1;
      TEC_CLK_DIV256: tick = (pre_q == TEC_PRE_LAST);
      TEC_CLK_CASCADE: tick = cascade_timer_irq;
      TEC_CLK_EVENT: tick = ev_edge;
    endcase
  end

  // match and clear conditions
  always_comb begin
    // pin edge clears in mode 10
    edge_clr = (op_mode_q == TEC_OP_EDGE_CLR) && ev_edge;
    clr_on_a = (op_mode_q == TEC_OP_MATCH_CLR);
    // compare B matches in every running mode
    hit_a = run && tick && started_q && !edge_clr && (cnt_q == cmp_a_q);
    hit_b = run && tick && started_q && !edge_clr && (cnt_q == cmp_b_q);
  end

  // up counter
  always_ff @(posedge sys_clk) begin
    if (rst || !run) begin
      cnt_q <= 16'h0000;
      started_q <= 1'b0;
    end else if (edge_clr) begin
      cnt_q <= 16'h0000;
      started_q <= 1'b1;
    end else if (tick) begin
      // sync tick gives M+2 first period
      // mode 10 does not wait for an edge
      if (!started_q) begin
        started_q <= 1'b1;
      end else if (clr_on_a && hit_a) begin
        cnt_q <= 16'h0000;
      end else begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end

  // output level; invert on compare A when enabled
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lvl_q <= 1'b0;
    end else if (!out_en) begin
      lvl_q <= 1'b0;
    end else if (hit_a && inv_en) begin
      lvl_q <= ~lvl_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      out_pin_q <= 1'b0;
    end else begin
      out_pin_q <= out_en & lvl_q;
    end
  end

  // interrupt status sets and write-one clears
  always_comb begin
    irq_set = 2'h0;
    irq_set[TEC_IRQ_A_POS] = hit_a;
    irq_set[TEC_IRQ_B_POS] = hit_b;
    irq_clr = 2'h0;
    if (bus_req.wr && bus_req.addr == TEC_OFS_IRQ_STAT) begin
      irq_clr = bus_req.wdata[1:0];
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_stat_q <= TEC_IRQ_RST;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
    end
  end

  // level interrupt from unmasked status
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_stat_q & ~irq_mask_q);
    end
  end

  // read data, one cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_data_q <= 16'h0000;
    end else if (bus_req.rd) begin
      unique case (bus_req.addr)
        TEC_OFS_MODE: rd_data_q <= {12'h000, op_mode_q, 2'h0};
        TEC_OFS_PRESCALE: rd_data_q <= {8'h00, prescale_mode_q};
        TEC_OFS_OUTCTRL: rd_data_q <= {14'h0000, out_ctrl_q};
        TEC_OFS_CMP_A: rd_data_q <= cmp_a_q;
        TEC_OFS_CMP_B: rd_data_q <= cmp_b_q;
        TEC_OFS_COUNT: rd_data_q <= cnt_q;
        TEC_OFS_IRQ_STAT: rd_data_q <= {14'h0000, irq_stat_q};
        TEC_OFS_IRQ_MASK: rd_data_q <= {14'h0000, irq_mask_q};
        default: rd_data_q <= 16'h0000;
      endcase
    end else begin
      rd_data_q <= 16'h0000;
    end
  end

  assign rd_data = rd_data_q;
  assign timer_out_pin = out_pin_q;
  assign irq = irq_q;

  // helper: ticks since start or since last compare A match
  logic [16:0] tick_n_q;
  logic first_q;
  always_ff @(posedge sys_clk) begin
    if (rst || !run) begin
      tick_n_q <= 17'h00000;
      first_q <= 1'b1;
    end else if (hit_a) begin
      tick_n_q <= 17'h00000;
      first_q <= 1'b0;
    end else if (tick && !edge_clr) begin
      tick_n_q <= tick_n_q + 17'h00001;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_match_clears: assert property (
    hit_a && clr_on_a |=> cnt_q == 16'h0000)
    else $error("counter not cleared on compare A match");

  a_match_irq_a: assert property (
    hit_a |=> irq_stat_q[TEC_IRQ_A_POS])
    else $error("compare A match did not set status");

  a_square_toggle: assert property (
    hit_a && inv_en && out_en |=> lvl_q != $past(lvl_q) ##1
    timer_out_pin == $past(lvl_q))
    else $error("output did not toggle on compare A match");

  a_toggle_gated: assert property (
    hit_a && !inv_en |=> lvl_q == $past(lvl_q) || !$past(out_en))
    else $error("output toggled with inversion disabled");

  a_out_forced_low: assert property (
    !out_en |=> !timer_out_pin)
    else $error("pin not low with output disabled");

  a_match_irq_b: assert property (
    hit_b |=> irq_stat_q[TEC_IRQ_B_POS])
    else $error("compare B match did not set status");

  a_first_period: assert property (
    hit_a && clr_on_a && first_q |-> tick_n_q == {1'b0, cmp_a_q} + 17'h00001)
    else $error("first compare A match not after M+2 count clocks");

  a_later_period: assert property (
    hit_a && clr_on_a && !first_q |-> tick_n_q == {1'b0, cmp_a_q})
    else $error("compare A period not M+1 count clocks");

  a_edge_clear: assert property (
    edge_clr |=> cnt_q == 16'h0000)
    else $error("pin edge did not clear the counter in mode 10");

  a_event_count: assert property (
    clk_sel == TEC_CLK_EVENT && clr_on_a && ev_edge && started_q && !hit_a
    |=> cnt_q == $past(cnt_q) + 16'h0001)
    else $error("event edge did not advance the counter");

  a_counter_wraps: assert property (
    run && tick && started_q && !edge_clr && cnt_q == TEC_CNT_MAX
    && !(hit_a && clr_on_a) |=> cnt_q == 16'h0000)
    else $error("counter did not wrap to zero");

  a_count_read: assert property (
    bus_req.rd && bus_req.addr == TEC_OFS_COUNT |=> rd_data == $past(cnt_q))
    else $error("counter read returned a wrong value");

  a_first_tick_syncs: assert property (
    run && tick && !started_q && !edge_clr |=> started_q && cnt_q == 16'h0000)
    else $error("first count clock did not only synchronise");

  a_stop_clears: assert property (
    !run |=> cnt_q == 16'h0000 && !started_q)
    else $error("stopped counter not held at zero");

  a_edge_mode_counts: assert property (
    op_mode_q == TEC_OP_EDGE_CLR && started_q && tick && !edge_clr
    |=> cnt_q == $past(cnt_q) + 16'h0001)
    else $error("counter did not advance in mode 10");

  a_irq_follows: assert property (
    irq == $past((irq_stat_q & ~irq_mask_q) != 2'h0))
    else $error("interrupt output does not follow unmasked status");

  c_square_wave: cover property (hit_a && clr_on_a && inv_en ##[1:64] hit_a);
  c_match_b: cover property (hit_b && run);
  c_edge_clear: cover property (edge_clr && cnt_q != 16'h0000);
  c_irq_out: cover property (irq ##1 !irq);
  c_cascade_tick: cover property (clk_sel == TEC_CLK_CASCADE && tick && started_q);
endmodule

// ### sim/tec_event_src.sv
`timescale 1ns/100ps
module tec_event_src (
  input wire logic sys_clk,
  output logic pin
);
  // pin idles low
  initial pin = 1'b0;
  task automatic pulse(input int hi);
    @(posedge sys_clk) pin <= 1'b1;
    repeat (hi) @(posedge sys_clk);
    pin <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask
endmodule

// ### sim/test_tec_timer.sv
`timescale 1ns/100ps
module test_tec_timer;
  import tec_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  tec_bus_req_t req = '0;
  logic [15:0] rd_data;
  logic ev_pin;
  logic casc = 1'b0;
  logic tout;
  logic irq;
  int err_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int n;
  logic [15:0] v;
  logic [15:0] w;

  tec_timer i_dut (
    .sys_clk(sys_clk),
    .rst(rst),
    .bus_req(req),
    .rd_data(rd_data),
    .event_in_pin(ev_pin),
    .cascade_timer_irq(casc),
    .timer_out_pin(tout),
    .irq(irq)
  );
  tec_event_src i_src (.sys_clk(sys_clk), .pin(ev_pin));

  // clock
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic complete_run();
    if (err_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc > 20000) begin
      err_count++;
      complete_run();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk) req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk) req <= '0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge sys_clk) req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge sys_clk) req <= '0;
    #1 d = rd_data;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] d;
    rd(a, d);
    chk(d, e);
  endtask

  // cycles until the output pin changes, 100 if never
  task automatic wait_tog(output int k);
    logic o;
    #1 o = tout;
    k = 0;
    while (tout === o && k < 100) begin
      @(posedge sys_clk);
      #1 k++;
    end
  endtask

  // stop, configure, clear status
  task automatic restart(input logic [7:0] pre, input logic [15:0] a, input logic [15:0] b);
    wr(TEC_OFS_MODE, 16'h0000);
    wr(TEC_OFS_PRESCALE, {8'h00, pre});
    wr(TEC_OFS_CMP_A, a);
    wr(TEC_OFS_CMP_B, b);
    wr(TEC_OFS_IRQ_STAT, 16'h0003);
  endtask

  // main sequence
  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    rchk(TEC_OFS_IRQ_MASK, 16'h0003);
    rchk(TEC_OFS_MODE, 16'h0000);
    rchk(TEC_OFS_IRQ_STAT, 16'h0000);
    rchk(TEC_OFS_COUNT, 16'h0000);
    rchk(8'h20, 16'h0000);
    // square wave, compare a 2, compare b 1
    restart(8'h00, 16'h0002, 16'h0001);
    wr(TEC_OFS_OUTCTRL, 16'h0003);
    wr(TEC_OFS_MODE, 16'h000C);
    wait_tog(n);
    wait_tog(n);
    chk(16'(n), 16'h0003);
    wait_tog(n);
    chk(16'(n), 16'h0003);
    rchk(TEC_OFS_IRQ_STAT, 16'h0003);
    chk({15'h0000, irq}, 16'h0000);
    // toggling off, match still flagged
    wr(TEC_OFS_OUTCTRL, 16'h0001);
    wr(TEC_OFS_IRQ_STAT, 16'h0003);
    wait_tog(n);
    wait_tog(n);
    chk(16'(n), 16'h0064);
    rchk(TEC_OFS_IRQ_STAT, 16'h0003);
    // output disabled forces low
    wr(TEC_OFS_OUTCTRL, 16'h0002);
    repeat (3) @(posedge sys_clk);
    repeat (12) begin
      @(posedge sys_clk);
      #1 chk({15'h0000, tout}, 16'h0000);
    end
    // event counting on rising edges, compare a 2
    restart(8'h13, 16'h0002, 16'hFFFF);
    wr(TEC_OFS_IRQ_MASK, 16'h0002);
    wr(TEC_OFS_MODE, 16'h000C);
    repeat (3) i_src.pulse(4);
    i_src.pulse(1);
    rchk(TEC_OFS_IRQ_STAT, 16'h0000);
    i_src.pulse(4);
    rchk(TEC_OFS_IRQ_STAT, 16'h0001);
    chk({15'h0000, irq}, 16'h0001);
    wr(TEC_OFS_IRQ_STAT, 16'h0001);
    rchk(TEC_OFS_IRQ_STAT, 16'h0000);
    @(posedge sys_clk);
    #1 chk({15'h0000, irq}, 16'h0000);
    repeat (2) i_src.pulse(4);
    rchk(TEC_OFS_IRQ_STAT, 16'h0000);
    i_src.pulse(4);
    rchk(TEC_OFS_IRQ_STAT, 16'h0001);
    // edge clear on falling edge, peripheral clock
    restart(8'h00, 16'h0005, 16'h0007);
    wr(TEC_OFS_MODE, 16'h0008);
    repeat (20) @(posedge sys_clk);
    rd(TEC_OFS_COUNT, v);
    rd(TEC_OFS_COUNT, w);
    chk(w - v, 16'h0002);
    chk({15'h0000, v != 16'h0000}, 16'h0001);
    rchk(TEC_OFS_IRQ_STAT, 16'h0003);
    i_src.pulse(4);
    rd(TEC_OFS_COUNT, v);
    chk({15'h0000, v < 16'h000C}, 16'h0001);
    // divide by 256
    restart(8'h01, 16'h0005, 16'h0007);
    wr(TEC_OFS_MODE, 16'h0008);
    repeat (600) @(posedge sys_clk);
    rd(TEC_OFS_COUNT, v);
    chk({15'h0000, v >= 16'h0001 && v <= 16'h0002}, 16'h0001);
    // cascade pulses as count clock, free run mode
    restart(8'h02, 16'h0005, 16'h0007);
    wr(TEC_OFS_MODE, 16'h0004);
    repeat (4) begin
      @(posedge sys_clk) casc <= 1'b1;
      @(posedge sys_clk) casc <= 1'b0;
    end
    rchk(TEC_OFS_COUNT, 16'h0003);
    // reset in mid-run returns to stopped, registers cleared
    @(posedge sys_clk) rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    rchk(TEC_OFS_COUNT, 16'h0000);
    rchk(TEC_OFS_PRESCALE, 16'h0000);
    complete_run();
  end
endmodule
